// file: common/timer_pkg.sv
// Constants, register map and field layout for the dual 8-bit timer block.
// Assumes a 32-bit AHB-Lite bus with one register per aligned word.
package timer_pkg;

  // Register byte offsets inside one timer and of the shared registers, and spacing between timers and channels
  localparam logic [7:0] OFF_CTL = 8'h00;
  localparam logic [7:0] OFF_CNT = 8'h04;
  localparam logic [7:0] OFF_CCTL0 = 8'h08;
  localparam logic [7:0] OFF_CC0 = 8'h0C;
  localparam logic [7:0] OFF_CCTL1 = 8'h10;
  localparam logic [7:0] OFF_CC1 = 8'h14;
  localparam logic [7:0] TIMER_STRIDE = 8'h20;
  localparam logic [7:0] OFF_FLAGS = 8'h40;
  localparam logic [7:0] OFF_CLKCFG = 8'h44;
  localparam logic [7:0] CH_STRIDE = 8'h08;

  // Timer control fields
  localparam int CTL_DIV_LSB = 5;
  localparam int CTL_START = 4;
  localparam int CTL_OVERFLOW_IRQ_MASK = 3;
  localparam int CTL_CLR = 2;
  localparam int CTL_MODE_LSB = 0;
  localparam logic [7:0] CTL_RST = 8'h08;

  // Channel compare control fields
  localparam int CCTL_IM = 6;
  localparam int CCTL_CMP_LSB = 3;
  localparam int CCTL_EN = 2;
  localparam logic [7:0] CCTL_RST = 8'h40;
  localparam logic [7:0] CCTL_WMASK = 8'h7F;

  // Shared flag register: three bits per timer
  localparam int FLG_OVF = 0;
  localparam int FLG_CH0 = 1;
  localparam int FLG_CH1 = 2;
  localparam int FLAGS_PER_TIMER = 3;

  // Counter landmarks
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_TOP = 8'hFF;

  // Timer counting modes
  typedef enum logic [1:0] {MODE_FREE, MODE_DOWN, MODE_MODULO, MODE_UPDOWN} mode_e;

  // Compare output actions
  localparam logic [2:0] CMP_SET = 3'h0;
  localparam logic [2:0] CMP_CLEAR = 3'h1;
  localparam logic [2:0] CMP_TOGGLE = 3'h2;
  localparam logic [2:0] CMP_SET_UP = 3'h3;
  localparam logic [2:0] CMP_CLR_UP = 3'h4;
  localparam logic [2:0] CMP_SET_FF = 3'h5;
  localparam logic [2:0] CMP_CLR_ZERO = 3'h6;

endpackage

// file: src/dual_timer.sv
// Two 8-bit timer/counters with two compare channels each, AHB-Lite slave.
// Assumes a single slave on the bus (hready equals hreadyout) and one clock.
// Overview of operation
// R1: Counter steps only on prescaled active edge
// R2: Prescaler divides tick by 1 to 128
// R3: Free mode counts 0x00 to 0xFF, wraps
// R4: Reaching 0xFF sets overflow flag, masked interrupt
// R5: Down mode loads compare 0, stops at zero
// R6: Modulo mode wraps at compare 0, flags overflow
// R7: Up/down mode counts 0 to compare and back
// R8: Start bit runs counter, zero halts it
// R9: Clear resets counter and direction to up
// R10: Counter value readable per timer
// R11: Two compare channels, each own pin
// R12: Software makes compare pins outputs first
// R13: Match sets, clears or toggles pin by mode
// R14: Compare pins driven from flip-flops
// R15: Software prefers modes 4 or 5 for PWM
// R16: One interrupt per timer, overflow or compare
// R17: One flag register holds all timer flags
// R18: Each channel match pulses its DMA trigger
// R19: Two-bit mode field selects counting mode
// R20: Three-bit compare code selects pin action
// R21: Compare 0 loads at zero, compare 1 immediately
// R22: Divider codes 0..7 map to 1..128
// R23: Flag and DMA trigger rise together
`timescale 1ns/1ps
module dual_timer
  import timer_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [1:0] cmp_out_ch0,
  output logic [1:0] cmp_out_ch1,
  output logic [1:0] dma_trigger_ch0,
  output logic [1:0] dma_trigger_ch1,
  output logic [1:0] timer_irq
);

  // Address of a register inside timer t
  function automatic logic [7:0] reg_addr(input int t, input logic [7:0] off);
    reg_addr = 8'(t * 32'(TIMER_STRIDE)) + off;
  endfunction
  // Low-bit mask for a power-of-two divide code
  function automatic logic [6:0] div_mask(input logic [2:0] code);
    div_mask = 7'((8'h01 << code) - 8'h01); // R22
  endfunction
  logic wr_en_r, wr_en_nxt;
  logic [7:0] wr_addr_r, wr_addr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic hreadyout_r;
  logic [2:0] tick_rate_select_r, tick_rate_select_nxt;
  logic [6:0] tick_cnt_r, tick_cnt_nxt;
  logic [6:0] presc_cnt_r, presc_cnt_nxt;
  logic tick;
  logic [7:0] timer_control_reg_r [2];
  logic [7:0] timer_control_reg_nxt [2];
  logic [7:0] cnt_r [2];
  logic [7:0] cnt_nxt [2];
  logic dir_down_r [2];
  logic dir_down_nxt [2];
  logic [7:0] cc0_eff_r [2];
  logic [7:0] cc0_eff_nxt [2];
  logic [7:0] channel_compare_value_r [2][2];
  logic [7:0] channel_compare_value_nxt [2][2];
  logic [7:0] channel_compare_control_r [2][2];
  logic [7:0] channel_compare_control_nxt [2][2];
  logic out_r [2][2];
  logic out_nxt [2][2];
  logic dma_r [2][2];
  logic dma_nxt [2][2];
  logic [2:0] flags_r [2];
  logic [2:0] flags_nxt [2];
  logic irq_r [2];
  logic irq_nxt [2];

  // Bus: take address phase, answer with zero wait states
  always_comb begin
    wr_en_nxt = hsel & hready & htrans[1] & hwrite;
    wr_addr_nxt = {haddr[7:2], 2'b00};
    hrdata_nxt = 32'h0000_0000;
    if (hsel & hready & htrans[1] & ~hwrite) begin
      for (int t = 0; t < 2; t++) begin
        if ({haddr[7:2], 2'b00} == reg_addr(t, OFF_CTL)) begin
          hrdata_nxt[7:0] = timer_control_reg_r[t];
        end else if ({haddr[7:2], 2'b00} == reg_addr(t, OFF_CNT)) begin
          hrdata_nxt[7:0] = cnt_r[t]; // R10
        end else if ({haddr[7:2], 2'b00} == reg_addr(t, OFF_CCTL0)) begin
          hrdata_nxt[7:0] = channel_compare_control_r[t][0];
        end else if ({haddr[7:2], 2'b00} == reg_addr(t, OFF_CC0)) begin
          hrdata_nxt[7:0] = channel_compare_value_r[t][0];
        end else if ({haddr[7:2], 2'b00} == reg_addr(t, OFF_CCTL1)) begin
          hrdata_nxt[7:0] = channel_compare_control_r[t][1];
        end else if ({haddr[7:2], 2'b00} == reg_addr(t, OFF_CC1)) begin
          hrdata_nxt[7:0] = channel_compare_value_r[t][1];
        end
      end
      if ({haddr[7:2], 2'b00} == OFF_FLAGS) begin
        hrdata_nxt[5:0] = {flags_r[1], flags_r[0]}; // R17
      end else if ({haddr[7:2], 2'b00} == OFF_CLKCFG) begin
        hrdata_nxt[2:0] = tick_rate_select_r;
      end
    end
  end
  // Bus registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_en_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
      hreadyout_r <= 1'b0;
    end else begin
      wr_en_r <= wr_en_nxt;
      wr_addr_r <= wr_addr_nxt;
      hrdata_r <= hrdata_nxt;
      hreadyout_r <= 1'b1;
    end
  end
  // Bus outputs
  assign hreadyout = hreadyout_r;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  // Tick rate and shared prescaler chain
  always_comb begin
    tick_rate_select_nxt = tick_rate_select_r;
    if (wr_en_r && wr_addr_r == OFF_CLKCFG) begin
      tick_rate_select_nxt = hwdata[2:0];
    end
    tick = (tick_cnt_r & div_mask(tick_rate_select_r)) == div_mask(tick_rate_select_r);
    tick_cnt_nxt = tick_cnt_r + 7'h01;
    presc_cnt_nxt = tick ? presc_cnt_r + 7'h01 : presc_cnt_r; // R2
  end
  // Tick registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_rate_select_r <= 3'h0;
      tick_cnt_r <= 7'h00;
      presc_cnt_r <= 7'h00;
    end else begin
      tick_rate_select_r <= tick_rate_select_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      presc_cnt_r <= presc_cnt_nxt;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_timer
      logic clr, start_load, act, up_step, ovf_ev, zero_hit, top_hit;
      logic cmp_ev [2];
      mode_e mode;
      logic [7:0] cmp_val [2];
      logic [2:0] code [2];

      // Counter, compare channels and flags of one timer
      always_comb begin
        timer_control_reg_nxt[gi] = timer_control_reg_r[gi];
        cnt_nxt[gi] = cnt_r[gi];
        dir_down_nxt[gi] = dir_down_r[gi];
        cc0_eff_nxt[gi] = cc0_eff_r[gi];
        flags_nxt[gi] = flags_r[gi];
        clr = 1'b0;
        start_load = 1'b0;
        ovf_ev = 1'b0;
        up_step = 1'b1;
        for (int j = 0; j < 2; j++) begin
          channel_compare_value_nxt[gi][j] = channel_compare_value_r[gi][j];
          channel_compare_control_nxt[gi][j] = channel_compare_control_r[gi][j];
          out_nxt[gi][j] = out_r[gi][j];
          cmp_ev[j] = 1'b0;
          code[j] = channel_compare_control_r[gi][j][CCTL_CMP_LSB +: 3];
        end
        mode = mode_e'(timer_control_reg_r[gi][CTL_MODE_LSB +: 2]); // R19
        act = tick && ((presc_cnt_r & div_mask(timer_control_reg_r[gi][CTL_DIV_LSB +: 3]))
              == div_mask(timer_control_reg_r[gi][CTL_DIV_LSB +: 3])); // R1
        act = act & timer_control_reg_r[gi][CTL_START]; // R8
        // Software writes
        if (wr_en_r) begin
          if (wr_addr_r == reg_addr(gi, OFF_CTL)) begin
            timer_control_reg_nxt[gi] = hwdata[7:0] & ~(8'h01 << CTL_CLR);
            clr = hwdata[CTL_CLR];
            start_load = hwdata[CTL_START] & ~timer_control_reg_r[gi][CTL_START]
                         & (hwdata[CTL_MODE_LSB +: 2] == MODE_DOWN);
          end
          for (int j = 0; j < 2; j++) begin
            if (wr_addr_r == reg_addr(gi, OFF_CC0 + 8'(j) * CH_STRIDE)) begin
              channel_compare_value_nxt[gi][j] = hwdata[7:0];
            end
            if (wr_addr_r == reg_addr(gi, OFF_CCTL0 + 8'(j) * CH_STRIDE)) begin
              channel_compare_control_nxt[gi][j] = hwdata[7:0] & CCTL_WMASK;
            end
          end
          if (wr_addr_r == OFF_FLAGS) begin
            flags_nxt[gi] = flags_r[gi] & hwdata[gi * FLAGS_PER_TIMER +: FLAGS_PER_TIMER];
          end
        end
        // Channel 0 shadow reloads at zero and on a down-mode start
        if (cnt_r[gi] == CNT_ZERO) begin
          cc0_eff_nxt[gi] = channel_compare_value_r[gi][0]; // R21
        end
        // Counting
        if (clr) begin
          cnt_nxt[gi] = CNT_ZERO; // R9
          dir_down_nxt[gi] = 1'b0; // R9
          act = 1'b0;
        end else if (start_load) begin
          cnt_nxt[gi] = channel_compare_value_r[gi][0]; // R5
          cc0_eff_nxt[gi] = channel_compare_value_r[gi][0];
          act = 1'b0;
        end else if (act) begin
          case (mode)
            MODE_FREE: begin
              cnt_nxt[gi] = cnt_r[gi] + 8'h01; // R3
              ovf_ev = (cnt_r[gi] == CNT_TOP - 8'h01); // R4
            end
            MODE_DOWN: begin
              up_step = 1'b0;
              if (cnt_r[gi] != CNT_ZERO) begin
                cnt_nxt[gi] = cnt_r[gi] - 8'h01; // R5
                ovf_ev = (cnt_r[gi] == 8'h01); // R5
              end
            end
            MODE_MODULO: begin
              if (cnt_r[gi] >= cc0_eff_r[gi]) begin
                cnt_nxt[gi] = CNT_ZERO; // R6
                ovf_ev = 1'b1; // R6
              end else begin
                cnt_nxt[gi] = cnt_r[gi] + 8'h01;
              end
            end
            default: begin
              if (!dir_down_r[gi] && cnt_r[gi] < cc0_eff_r[gi]) begin
                cnt_nxt[gi] = cnt_r[gi] + 8'h01; // R7
              end else if (cnt_r[gi] != CNT_ZERO) begin
                up_step = 1'b0;
                cnt_nxt[gi] = cnt_r[gi] - 8'h01; // R7
                dir_down_nxt[gi] = (cnt_r[gi] != 8'h01);
                ovf_ev = (cnt_r[gi] == 8'h01);
              end else begin
                dir_down_nxt[gi] = 1'b0;
              end
            end
          endcase
        end
        // Compare matches drive the pins
        cmp_val[0] = cc0_eff_r[gi];
        cmp_val[1] = channel_compare_value_nxt[gi][1]; // R21
        zero_hit = act && cnt_nxt[gi] == CNT_ZERO;
        top_hit = act && cnt_nxt[gi] == CNT_TOP;
        for (int j = 0; j < 2; j++) begin
          cmp_ev[j] = act && channel_compare_control_r[gi][j][CCTL_EN]
                      && cnt_nxt[gi] == cmp_val[j]; // R13
          case (code[j])
            CMP_SET: begin
              if (cmp_ev[j]) out_nxt[gi][j] = 1'b1; // R20
            end
            CMP_CLEAR: begin
              if (cmp_ev[j]) out_nxt[gi][j] = 1'b0; // R20
            end
            CMP_TOGGLE: begin
              if (cmp_ev[j]) out_nxt[gi][j] = ~out_r[gi][j]; // R20
            end
            CMP_SET_UP: begin
              if (cmp_ev[j]) out_nxt[gi][j] = up_step;
              else if (zero_hit) out_nxt[gi][j] = 1'b0; // R20
            end
            CMP_CLR_UP: begin
              if (cmp_ev[j]) out_nxt[gi][j] = ~up_step;
              else if (zero_hit) out_nxt[gi][j] = 1'b1; // R20
            end
            CMP_SET_FF: begin
              if (cmp_ev[j]) out_nxt[gi][j] = 1'b1;
              else if (top_hit) out_nxt[gi][j] = 1'b0; // R20
            end
            CMP_CLR_ZERO: begin
              if (cmp_ev[j]) out_nxt[gi][j] = 1'b0;
              else if (zero_hit) out_nxt[gi][j] = 1'b1; // R20
            end
            default: out_nxt[gi][j] = out_r[gi][j]; // Code 111 holds the pin
          endcase
          dma_nxt[gi][j] = cmp_ev[j]; // R18
        end
        // Events set flags after any clear
        flags_nxt[gi][FLG_OVF] = flags_nxt[gi][FLG_OVF] | ovf_ev; // R4
        flags_nxt[gi][FLG_CH0] = flags_nxt[gi][FLG_CH0] | cmp_ev[0]; // R23
        flags_nxt[gi][FLG_CH1] = flags_nxt[gi][FLG_CH1] | cmp_ev[1]; // R23
        irq_nxt[gi] = (flags_nxt[gi][FLG_OVF] & timer_control_reg_nxt[gi][CTL_OVERFLOW_IRQ_MASK])
                    | (flags_nxt[gi][FLG_CH0] & channel_compare_control_nxt[gi][0][CCTL_IM])
                    | (flags_nxt[gi][FLG_CH1] & channel_compare_control_nxt[gi][1][CCTL_IM]);
      end
      // Timer registers
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          timer_control_reg_r[gi] <= CTL_RST;
          cnt_r[gi] <= CNT_ZERO;
          dir_down_r[gi] <= 1'b0;
          cc0_eff_r[gi] <= CNT_ZERO;
          flags_r[gi] <= 3'h0;
          irq_r[gi] <= 1'b0;
          for (int j = 0; j < 2; j++) begin
            channel_compare_value_r[gi][j] <= CNT_ZERO;
            channel_compare_control_r[gi][j] <= CCTL_RST;
            out_r[gi][j] <= 1'b0;
            dma_r[gi][j] <= 1'b0;
          end
        end else begin
          timer_control_reg_r[gi] <= timer_control_reg_nxt[gi];
          cnt_r[gi] <= cnt_nxt[gi];
          dir_down_r[gi] <= dir_down_nxt[gi];
          cc0_eff_r[gi] <= cc0_eff_nxt[gi];
          flags_r[gi] <= flags_nxt[gi];
          irq_r[gi] <= irq_nxt[gi]; // R16
          for (int j = 0; j < 2; j++) begin
            channel_compare_value_r[gi][j] <= channel_compare_value_nxt[gi][j];
            channel_compare_control_r[gi][j] <= channel_compare_control_nxt[gi][j];
            out_r[gi][j] <= out_nxt[gi][j]; // R14
            dma_r[gi][j] <= dma_nxt[gi][j];
          end
        end
      end
      // Pins and triggers straight from flip-flops
      assign cmp_out_ch0[gi] = out_r[gi][0]; // R11
      assign cmp_out_ch1[gi] = out_r[gi][1]; // R11
      assign dma_trigger_ch0[gi] = dma_r[gi][0];
      assign dma_trigger_ch1[gi] = dma_r[gi][1];
      assign timer_irq[gi] = irq_r[gi];
    end
  endgenerate
endmodule // dual_timer

// file: tb/dual_timer_properties.sv
// Concurrent checks on the ports of the dual timer block.
// Assumes one clock and an async active-low reset; bound from the testbench.
`timescale 1ns/1ps
module timer_checker
  import timer_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [1:0] cmp_out_ch0,
  input wire logic [1:0] cmp_out_ch1,
  input wire logic [1:0] dma_trigger_ch0,
  input wire logic [1:0] dma_trigger_ch1,
  input wire logic [1:0] timer_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Address phases seen by the slave
  sequence s_rd_req;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence s_wr_req;
    hsel && hready && htrans[1] && hwrite;
  endsequence
  sequence s_no_req;
    !(hsel && hready && htrans[1]);
  endsequence

  // Bus answers
  property p_okay;
    hresp == 1'b0;
  endproperty
  property p_ready;
    $past(rst_n) |-> hreadyout;
  endproperty
  property p_upper;
    s_rd_req |=> hrdata[31:8] == 24'h00_0000;
  endproperty
  property p_wr_quiet;
    s_wr_req |=> hrdata == 32'h0000_0000;
  endproperty
  property p_idle;
    s_no_req |=> hrdata == 32'h0000_0000;
  endproperty
  // Trigger lines pulse for one cycle only
  property p_dma00;
    dma_trigger_ch0[0] |=> !dma_trigger_ch0[0];
  endproperty
  property p_dma01;
    dma_trigger_ch0[1] |=> !dma_trigger_ch0[1];
  endproperty
  property p_dma10;
    $rose(dma_trigger_ch1[0]) |=> $fell(dma_trigger_ch1[0]);
  endproperty
  property p_dma11;
    $rose(dma_trigger_ch1[1]) |=> $fell(dma_trigger_ch1[1]);
  endproperty

  a_okay: assert property (p_okay) else $error("hresp not OKAY");
  a_ready: assert property (p_ready) else $error("hreadyout low");
  a_upper: assert property (p_upper) else $error("read upper bits set");
  a_wr_quiet: assert property (p_wr_quiet) else $error("hrdata after write");
  a_idle: assert property (p_idle) else $error("hrdata while idle");
  a_dma00: assert property (p_dma00) else $error("trigger t0c0 long");
  a_dma01: assert property (p_dma01) else $error("trigger t1c0 long");
  a_dma10: assert property (p_dma10) else $error("trigger t0c1 long");
  a_dma11: assert property (p_dma11) else $error("trigger t1c1 long");
endmodule // timer_checker

// file: tb/pin_side.sv
// Model of the loads on the compare pins and the DMA trigger lines.
// Assumes the block's clock and async active-low reset.
`timescale 1ns/1ps
module pin_side (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] dma,
  input wire logic [3:0] pins,
  output logic [3:0] level,
  output logic [15:0] gap [4]
);
  logic [15:0] run [4];
  // Pins act as driven outputs into the load
  assign level = pins;
  // Cycles between successive pulses on each trigger line
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        run[i] <= 16'h0000;
        gap[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        run[i] <= dma[i] ? 16'h0001 : run[i] + 16'h0001;
        if (dma[i]) begin
          gap[i] <= run[i];
        end
      end
    end
  end
endmodule // pin_side

// file: tb/testbench.sv
// Self-checking bench for the dual timer over AHB-Lite register tasks.
// Assumes checker and pin model compiled first; hready tied to hreadyout.
`timescale 1ns/1ps
module testbench;
  import timer_pkg::*;
  logic clk, rst_n, hsel, hwrite, hreadyout, hresp, p, e;
  logic [7:0] haddr;
  logic [1:0] htrans, out0, out1, dma0, dma1, irq;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [3:0] level;
  logic [15:0] gap [4];
  logic [3:0] trig;
  int bad_count = 0;
  int cmp_count = 0;

  dual_timer dut_u (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmp_out_ch0(out0),
    .cmp_out_ch1(out1), .dma_trigger_ch0(dma0), .dma_trigger_ch1(dma1), .timer_irq(irq));
  pin_side model_u (.clk(clk), .rst_n(rst_n), .dma({dma1, dma0}), .pins({out1, out0}),
    .level(level), .gap(gap));
  // Trigger lines as one vector for polling
  assign trig = {dma1, dma0};

  // Clock source
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  // Wait for hready high at a rising edge
  task automatic rdy();
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) chk(0, 1, "bus hang");
  endtask
  // One single word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, wd};
    rdy();
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] x, input string m);
    bus(1'b0, a, 8'h00);
    chk(rd, {24'h00_0000, x}, m);
  endtask
  // Wait for a trigger pulse, bounded
  task automatic waitp(input int i);
    int n;
    n = 0;
    @(posedge clk);
    while (trig[i] !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (n == 5000) chk(0, 1, "no trigger pulse");
  endtask
  task automatic gapm(input int i, input logic [31:0] x);
    waitp(i);
    waitp(i);
    @(posedge clk);
    chk(gap[i], x, "trigger spacing");
  endtask
  // Verdict and end of run
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    end_sim();
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rchk(OFF_CTL, CTL_RST, "control reset");
    rchk(TIMER_STRIDE + OFF_CCTL1, CCTL_RST, "channel control reset");
    bus(1'b1, OFF_CNT, 8'h55);
    rchk(OFF_CNT, 8'h00, "counter read-only");
    bus(1'b1, 8'h48, 8'hAA);
    rchk(8'h48, 8'h00, "unmapped");
    // Every output code on timer 0 channel 1, free running
    bus(1'b1, OFF_CC1, 8'h05);
    bus(1'b1, OFF_CTL, 8'h18);
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, OFF_CCTL1, 8'h44 | 8'(c << 3));
      p = level[2];
      e = (c == 0 || c == 3 || c == 5);
      if (c == 2) e = ~p;
      if (c == 7) e = p;
      waitp(2);
      chk(level[2], e, "pin action");
    end
    // Halt, flags, interrupt and clear
    bus(1'b1, OFF_CTL, 8'h08);
    rchk(OFF_FLAGS, 8'h05, "flags after wraps");
    chk(irq[0], 1'b1, "timer 0 irq");
    bus(1'b0, OFF_CNT, 8'h00);
    repeat (20) @(posedge clk);
    rchk(OFF_CNT, rd[7:0], "halted count");
    bus(1'b1, OFF_FLAGS, 8'h00);
    rchk(OFF_FLAGS, 8'h00, "flags cleared");
    chk(irq[0], 1'b0, "irq dropped");
    bus(1'b1, OFF_CTL, 8'h0C);
    rchk(OFF_CNT, 8'h00, "counter clear");
    // Modulo, up/down and down modes on channel 0
    bus(1'b1, OFF_CC0, 8'h09);
    bus(1'b1, OFF_CCTL0, 8'h44);
    bus(1'b1, OFF_CTL, 8'h1A);
    gapm(0, 10);
    chk(level[0], 1'b1, "timer 0 channel 0 pin set");
    bus(1'b1, OFF_CTL, 8'h1F);
    gapm(0, 18);
    bus(1'b1, OFF_CTL, 8'h0C);
    bus(1'b1, OFF_FLAGS, 8'h00);
    bus(1'b1, OFF_CTL, 8'h19);
    repeat (30) @(posedge clk);
    rchk(OFF_CNT, 8'h00, "down stops at zero");
    bus(1'b0, OFF_FLAGS, 8'h00);
    chk(rd[0], 1'b1, "down overflow");
    // Prescaler and tick rate on timer 1
    bus(1'b1, TIMER_STRIDE + OFF_CC1, 8'h05);
    bus(1'b1, TIMER_STRIDE + OFF_CCTL1, 8'h44);
    bus(1'b1, TIMER_STRIDE + OFF_CCTL0, 8'h44);
    for (int d = 0; d < 4; d++) begin
      bus(1'b1, TIMER_STRIDE + OFF_CTL, 8'(d << 5) | 8'h18);
      gapm(3, 32'd256 << d);
    end
    waitp(1);
    chk(level[1], 1'b1, "timer 1 channel 0 pin set");
    chk(level[3], 1'b1, "timer 1 channel 1 pin set");
    chk(irq[1], 1'b1, "timer 1 irq");
    bus(1'b1, OFF_CLKCFG, 8'h01);
    bus(1'b1, TIMER_STRIDE + OFF_CTL, 8'h18);
    gapm(3, 512);
    end_sim();
  end
endmodule // testbench

bind dual_timer timer_checker chk_u (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
  .hwdata, .hready, .hreadyout, .hresp, .hrdata, .cmp_out_ch0, .cmp_out_ch1,
  .dma_trigger_ch0, .dma_trigger_ch1, .timer_irq);
